// ===== hdl/afc_pkg.sv
// Shared constants for the receive-side automatic flow control block.
// Assumes a single 50 MHz core clock shared with the MAC and RX FIFO.
package afc_pkg;

  // ****************************************************************
  // Register placement and layout
  // ****************************************************************
  localparam logic [7:0] AUTO_FLOW_CONTROL_CONFIG_OFFSET = 8'hac;      // Config register offset
  localparam logic [31:0] AUTO_FLOW_CONTROL_CONFIG_RESET = 32'h0000_0000; // Config reset value
  localparam int HI_LSB = 16;                          // High threshold field
  localparam int HI_MSB = 23;
  localparam int LO_LSB = 8;                           // Low threshold field
  localparam int LO_MSB = 15;
  localparam int JAM_LSB = 4;                          // Jam duration code field
  localparam int JAM_MSB = 7;
  localparam int TRIG_MULTICAST_BIT = 3;               // Trigger class bits
  localparam int TRIG_BROADCAST_BIT = 2;
  localparam int TRIG_OWN_ADDR_BIT = 1;
  localparam int TRIG_ANY_BIT = 0;
  localparam int CFG_USED_MSB = 23;                    // Bits above read as zero
  localparam int THR_UNIT_SHIFT = 6;                   // Thresholds count 64 bytes

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_FREQ_MHZ = 50;                    // Core clock rate
  localparam int JAM_STEP_NS = 5000;                   // 5 us base jam step
  localparam int JAM_EXTRA_10M_NS = 2200;              // 2.2 us added at 10 Mb/s
  localparam int JAM_STEP_CYC = (JAM_STEP_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int JAM_EXTRA_10M_CYC = (JAM_EXTRA_10M_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int JAM_TABLE_STEP = 10;                  // Codes 4..F: 50 us per step
  localparam int JAM_TABLE_BASE = 3;                   // Code offset for stepped range

  // ****************************************************************
  // Full-duplex pause sequencing
  // ****************************************************************
  typedef enum logic [1:0] {
    AFC_IDLE = 2'b00,      // Waiting for the high level
    AFC_PAUSE_REQ = 2'b01, // Pause with programmed time requested
    AFC_PAUSED = 2'b10,    // Pause sent, waiting for the low level
    AFC_ZERO_REQ = 2'b11   // Zero-time pause requested
  } afc_state_t;

endpackage

// ===== hdl/afc_jam_rom.sv
// Jam duration lookup: turns the 4-bit code and link speed into cycles.
// Assumes code and speed are stable a cycle before a jam is started.
`timescale 1ns/100ps
`default_nettype none

module afc_jam_rom #(
  parameter int CNT_W = 16,
  parameter int STEP_CYC = afc_pkg::JAM_STEP_CYC,
  parameter int EXTRA_CYC = afc_pkg::JAM_EXTRA_10M_CYC
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  // Lookup request
  input wire logic [3:0] code_in,
  input wire logic speed_10_in,
  // Registered duration in cycles
  output logic [CNT_W-1:0] cycles_out
);

  logic [6:0] mult;           // Duration in 5 us steps
  logic [CNT_W-1:0] cycles_d; // Next registered duration

  // ****************************************************************
  // Table lookup
  // ****************************************************************
  // Codes 0..3 are irregular, the rest step by 50 us
  always_comb
  begin
    case (code_in)
      4'h0: mult = 7'h01;
      4'h1: mult = 7'h02;
      4'h2: mult = 7'h03;
      4'h3: mult = 7'h05;
      default: mult = 7'((int'(code_in) - afc_pkg::JAM_TABLE_BASE) * afc_pkg::JAM_TABLE_STEP);
    endcase
    // Slow link adds a fixed extra time
    cycles_d = CNT_W'(int'(mult) * STEP_CYC + (speed_10_in ? EXTRA_CYC : 0));
  end

  // Output register
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      cycles_out <= '0;
    else
      cycles_out <= cycles_d;
  end

endmodule
`default_nettype wire

// ===== hdl/afc_ctrl.sv
// Receive-side automatic flow control: pause frames and timed back pressure.
// Assumes MAC, RX FIFO and config write port share ref_clk_in.
//
// How it works
// - Below low level, send zero-time pause
// - Zero pause only after enabled, sent pause
// - Jam code sets jam length, ignored FD
// - Jam table in 5/50 us steps, +2.2us
// - Multicast trigger jams in half duplex
// - Broadcast trigger jams in half duplex
// - Own-address trigger jams in half duplex
// - Any-frame trigger enables jam or pause
// - Half duplex any-frame acts on preamble
// - Full duplex any-frame requests pause immediately
// - Any-frame overrides the other trigger bits
// - High level sends one programmed pause
// - Each matching half duplex frame jammed at or above high level
// - Nothing sent while transmitter disabled
`timescale 1ns/100ps
`default_nettype none

module afc_ctrl #(
  parameter int USED_W = 15,                            // FIFO byte count width
  parameter int CNT_W = 16,                             // Jam counter width
  parameter int JAM_STEP_CYCLES = afc_pkg::JAM_STEP_CYC,
  parameter int JAM_EXTRA_CYCLES = afc_pkg::JAM_EXTRA_10M_CYC
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  // Config register port
  input wire logic cfg_wr_en_in,
  input wire logic [31:0] cfg_wr_data_in,
  output logic [31:0] cfg_rd_data_out,
  // RX FIFO level and link state
  input wire logic [USED_W-1:0] rx_fifo_used_in,
  input wire logic full_duplex_in,
  input wire logic speed_10_in,
  input wire logic tx_enabled_in,
  // Receive frame events
  input wire logic rx_preamble_in,
  input wire logic rx_da_valid_in,
  input wire logic rx_da_multicast_in,
  input wire logic rx_da_broadcast_in,
  input wire logic rx_da_own_in,
  // MAC transmitter handshake
  input wire logic pause_ack_in,
  output logic pause_req_out,
  output logic pause_zero_out,
  output logic backpressure_out
);

  // ****************************************************************
  // Configuration register
  // ****************************************************************
  logic [31:0] cfg_q;                 // Stored config
  logic [31:0] cfg_d;
  logic [USED_W-1:0] hi_bytes;        // High level in bytes
  logic [USED_W-1:0] lo_bytes;        // Low level in bytes
  logic level_reached;                // FIFO at or above high level
  logic below_low;                    // FIFO under low level
  logic trig_any;
  logic [3:0] jam_code;

  // Write decode, reserved bits kept zero
  always_comb
  begin
    cfg_d = cfg_q;
    if (cfg_wr_en_in)
      cfg_d = {8'h00, cfg_wr_data_in[afc_pkg::CFG_USED_MSB:0]};
  end

  // Config storage doubles as read data
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      cfg_q <= afc_pkg::AUTO_FLOW_CONTROL_CONFIG_RESET;
    else
      cfg_q <= cfg_d;
  end

  assign cfg_rd_data_out = cfg_q;

  // Threshold scaling and continuous comparison
  assign hi_bytes = USED_W'({cfg_q[afc_pkg::HI_MSB:afc_pkg::HI_LSB], 6'h00});
  assign lo_bytes = USED_W'({cfg_q[afc_pkg::LO_MSB:afc_pkg::LO_LSB], 6'h00});
  assign level_reached = (rx_fifo_used_in >= hi_bytes);
  assign below_low = (rx_fifo_used_in < lo_bytes);
  assign trig_any = cfg_q[afc_pkg::TRIG_ANY_BIT];
  assign jam_code = cfg_q[afc_pkg::JAM_MSB:afc_pkg::JAM_LSB];

  // ****************************************************************
  // Full-duplex pause sequencing
  // ****************************************************************
  afc_pkg::afc_state_t state_q;
  afc_pkg::afc_state_t state_d;
  logic pause_req_d;
  logic pause_zero_d;
  logic fd_active;                    // Pause flow control allowed

  // Pause path runs only in full duplex with any-frame set
  assign fd_active = full_duplex_in && trig_any;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      // Request a programmed pause as soon as the level is hit
      afc_pkg::AFC_IDLE:
      begin
        if (fd_active && level_reached && tx_enabled_in)
          state_d = afc_pkg::AFC_PAUSE_REQ;
      end
      // Wait for the MAC to take the frame
      afc_pkg::AFC_PAUSE_REQ:
      begin
        if (!fd_active)
          state_d = afc_pkg::AFC_IDLE;
        else if (pause_req_out && pause_ack_in)
          state_d = afc_pkg::AFC_PAUSED;
      end
      // Only one pause per crossing; wait for the drain
      afc_pkg::AFC_PAUSED:
      begin
        if (!fd_active)
          state_d = afc_pkg::AFC_IDLE;
        else if (below_low && tx_enabled_in)
          state_d = afc_pkg::AFC_ZERO_REQ;
      end
      // Zero-time pause releases the partner
      afc_pkg::AFC_ZERO_REQ:
      begin
        if (!fd_active || (pause_req_out && pause_ack_in))
          state_d = afc_pkg::AFC_IDLE;
      end
      default: state_d = afc_pkg::AFC_IDLE;
    endcase
    // Request held off while the transmitter is off
    pause_req_d = tx_enabled_in && fd_active &&
      ((state_d == afc_pkg::AFC_PAUSE_REQ) || (state_d == afc_pkg::AFC_ZERO_REQ));
    pause_zero_d = (state_d == afc_pkg::AFC_ZERO_REQ);
  end

  // State and handshake registers
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_q <= afc_pkg::AFC_IDLE;
      pause_req_out <= 1'b0;
      pause_zero_out <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      pause_req_out <= pause_req_d;
      pause_zero_out <= pause_zero_d;
    end
  end

  // ****************************************************************
  // Half-duplex back pressure
  // ****************************************************************
  logic [CNT_W-1:0] jam_cycles;       // Looked-up duration
  logic [CNT_W-1:0] jam_cnt_q;
  logic [CNT_W-1:0] jam_cnt_d;
  logic jam_d;
  logic class_hit;                    // Decoded frame matches a class bit
  logic jam_start;

  afc_jam_rom #(
    .CNT_W(CNT_W),
    .STEP_CYC(JAM_STEP_CYCLES),
    .EXTRA_CYC(JAM_EXTRA_CYCLES)
  ) u_jam_rom (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .code_in(jam_code),
    .speed_10_in(speed_10_in),
    .cycles_out(jam_cycles)
  );

  // Trigger on a matching frame once the level is reached
  always_comb
  begin
    class_hit = rx_da_valid_in &&
      ((cfg_q[afc_pkg::TRIG_MULTICAST_BIT] && rx_da_multicast_in) ||
       (cfg_q[afc_pkg::TRIG_BROADCAST_BIT] && rx_da_broadcast_in) ||
       (cfg_q[afc_pkg::TRIG_OWN_ADDR_BIT] && rx_da_own_in));
    // Any-frame skips address decode and masks the class bits
    jam_start = !full_duplex_in && tx_enabled_in && level_reached &&
      (trig_any ? rx_preamble_in : class_hit);
    jam_cnt_d = jam_cnt_q;
    if (full_duplex_in || !tx_enabled_in)
      jam_cnt_d = '0;
    else if (jam_start)
      jam_cnt_d = jam_cycles;
    else if (jam_cnt_q != '0)
      jam_cnt_d = jam_cnt_q - CNT_W'(1);
    jam_d = (jam_cnt_d != '0);
  end

  // Jam timer and back pressure output
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      jam_cnt_q <= '0;
      backpressure_out <= 1'b0;
    end
    else
    begin
      jam_cnt_q <= jam_cnt_d;
      backpressure_out <= jam_d;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_zero_after_low;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    (state_q == afc_pkg::AFC_PAUSED) && fd_active && below_low && tx_enabled_in
      |=> pause_req_out && pause_zero_out;
  endproperty
  a_zero_after_low: assert property (p_zero_after_low) else $error("no zero pause");

  property p_zero_needs_pause;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    $rose(pause_zero_out) |-> $past(state_q) == afc_pkg::AFC_PAUSED;
  endproperty
  a_zero_needs_pause: assert property (p_zero_needs_pause) else $error("stray zero");

  property p_fd_no_jam;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    full_duplex_in |=> !backpressure_out;
  endproperty
  a_fd_no_jam: assert property (p_fd_no_jam) else $error("jam in full duplex");

  property p_jam_length;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    jam_start |=> (jam_cnt_q == $past(jam_cycles)) && backpressure_out;
  endproperty
  a_jam_length: assert property (p_jam_length) else $error("jam length wrong");

  property p_mcast_jam;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    !full_duplex_in && tx_enabled_in && level_reached && !trig_any && rx_da_valid_in &&
      rx_da_multicast_in && cfg_q[afc_pkg::TRIG_MULTICAST_BIT] |=> backpressure_out;
  endproperty
  a_mcast_jam: assert property (p_mcast_jam) else $error("multicast not jammed");

  property p_bcast_jam;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    !full_duplex_in && tx_enabled_in && level_reached && !trig_any && rx_da_valid_in &&
      rx_da_broadcast_in && cfg_q[afc_pkg::TRIG_BROADCAST_BIT] |=> backpressure_out;
  endproperty
  a_bcast_jam: assert property (p_bcast_jam) else $error("broadcast not jammed");

  property p_own_jam;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    !full_duplex_in && tx_enabled_in && level_reached && !trig_any && rx_da_valid_in &&
      rx_da_own_in && cfg_q[afc_pkg::TRIG_OWN_ADDR_BIT] |=> backpressure_out;
  endproperty
  a_own_jam: assert property (p_own_jam) else $error("own frame not jammed");

  property p_fd_pause;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    (state_q == afc_pkg::AFC_IDLE) && fd_active && level_reached && tx_enabled_in
      |=> pause_req_out && !pause_zero_out;
  endproperty
  a_fd_pause: assert property (p_fd_pause) else $error("no pause request");

  property p_any_preamble;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    !full_duplex_in && tx_enabled_in && level_reached && trig_any && rx_preamble_in
      |=> backpressure_out;
  endproperty
  a_any_preamble: assert property (p_any_preamble) else $error("preamble not jammed");

  property p_any_masks;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    trig_any && !rx_preamble_in && !backpressure_out && (jam_cnt_q == '0) |=> !backpressure_out;
  endproperty
  a_any_masks: assert property (p_any_masks) else $error("class bit acted");

  property p_tx_off;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    !tx_enabled_in |=> !pause_req_out && !backpressure_out;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("sent with tx off");

  c_pause_cycle: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    pause_req_out && !pause_zero_out ##[1:1000] pause_req_out && pause_zero_out);
  c_jam_end: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    $fell(backpressure_out));
  c_jam_start: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in) jam_start);

endmodule
`default_nettype wire

// ===== dv/afc_mac_model.sv
// MAC transmitter model: accepts pause requests after a chosen delay.
// Assumes one clock shared with the flow controller.
`timescale 1ns/100ps
`default_nettype none

module afc_mac_model (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  // Pause handshake
  input wire logic pause_req_in,
  input wire logic pause_zero_in,
  input wire logic [3:0] ack_dly_in,
  output logic pause_ack_out,
  // Accepted frames: programmed time and zero time
  output logic [7:0] n_pause_out,
  output logic [7:0] n_zero_out
);
  logic [3:0] wait_q; // Cycles the request has waited

  // One ack pulse per request, once the transmit window opens
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pause_ack_out <= 1'b0;
      wait_q <= 4'h0;
      n_pause_out <= 8'h00;
      n_zero_out <= 8'h00;
    end
    else
    begin
      pause_ack_out <= 1'b0;
      wait_q <= 4'h0;
      // Window open: take the frame
      if (pause_req_in && !pause_ack_out && wait_q >= ack_dly_in)
      begin
        pause_ack_out <= 1'b1;
        n_pause_out <= n_pause_out + {7'h00, !pause_zero_in};
        n_zero_out <= n_zero_out + {7'h00, pause_zero_in};
      end
      // Still busy: count the stall
      else if (pause_req_in && !pause_ack_out)
        wait_q <= wait_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ===== dv/rx_auto_flow_control_tb.sv
// Self-checking bench for the receive-side flow control block.
// Assumes afc_ctrl and afc_mac_model compile first; one 50 MHz clock.
`timescale 1ns/100ps
`default_nettype none

module rx_auto_flow_control_tb;
  // ****************
  // Signals
  // ****************
  logic ref_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wr_data = 32'h0;
  logic [31:0] rd_data;
  logic [14:0] used = 15'h0;
  logic fd = 1'b0;
  logic s10 = 1'b0;
  logic tx_en = 1'b1;
  logic pre = 1'b0;
  logic dav = 1'b0;
  logic [2:0] cls = 3'h0; // Multicast, broadcast, own address
  logic [3:0] ack_dly = 4'h0;
  logic req, zero, bp, ack;
  logic [7:0] n_pause, n_zero;
  logic [15:0] lfsr = 16'h002c;
  logic [15:0] cnt0;
  int fails = 0;
  int n_tests = 0;
  int i, hi, lo;

  // 20 ns clock
  always #10 ref_clk_in = ~ref_clk_in;

  afc_ctrl #(.USED_W(15), .CNT_W(16), .JAM_STEP_CYCLES(4), .JAM_EXTRA_CYCLES(2)) DUT (
    .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .cfg_wr_en_in(wr_en),
    .cfg_wr_data_in(wr_data), .cfg_rd_data_out(rd_data), .rx_fifo_used_in(used),
    .full_duplex_in(fd), .speed_10_in(s10), .tx_enabled_in(tx_en), .rx_preamble_in(pre),
    .rx_da_valid_in(dav), .rx_da_multicast_in(cls[2]), .rx_da_broadcast_in(cls[1]),
    .rx_da_own_in(cls[0]), .pause_ack_in(ack), .pause_req_out(req),
    .pause_zero_out(zero), .backpressure_out(bp));

  afc_mac_model MAC (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .pause_req_in(req),
    .pause_zero_in(zero), .ack_dly_in(ack_dly), .pause_ack_out(ack),
    .n_pause_out(n_pause), .n_zero_out(n_zero));

  // ****************
  // Helpers
  // ****************
  // Pseudo-random step
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Expected jam cycles: steps of 4, 2 more at 10 Mb/s
  function automatic int jlen(input int code, input int slow);
    int m;
    m = (code < 3) ? code + 1 : (code == 3) ? 5 : (code - 3) * 10;
    return m * 4 + slow * 2;
  endfunction

  // Config word from its fields
  function automatic logic [31:0] cfg(input int h, input int l, input int j, input int t);
    return {8'h00, 8'(h), 8'(l), 4'(j), 4'(t)};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // One-cycle write strobe, then readback settles
  task automatic wr(input logic [31:0] d);
    wr_en = 1'b1;
    wr_data = d;
    cyc(1);
    wr_en = 1'b0;
    cyc(1);
  endtask

  // Bounded wait for the MAC model to take a frame
  task automatic wait_mac(input logic [15:0] old);
    int k;
    for (k = 0; k < 40 && {n_pause, n_zero} === old; k++)
      cyc(1);
    if (k == 40)
    begin
      fails++;
      $display("BAD t=%0t pause not taken", $time);
      print_verdict();
    end
  endtask

  // Frame event, then measure the jam length
  task automatic jam(input logic p, input logic [2:0] c, input int exp);
    int k;
    pre = p;
    dav = ~p;
    cls = c;
    cyc(1);
    pre = 1'b0;
    dav = 1'b0;
    cls = 3'h0;
    for (k = 0; k < 600 && bp === 1'b1; k++)
      cyc(1);
    chk(32'(k), 32'(exp));
    // A jam that never ends has used up its bound: stop here
    if (k == 600)
      print_verdict();
    cyc(2);
  endtask

  // ****************
  // Sequence
  // ****************
  initial
  begin
    repeat (12) @(posedge ref_clk_in);
    cyc(1);
    chk(rd_data, 32'h0);
    arst_n_in = 1'b1;
    wr(32'hffffffff);
    chk(rd_data, 32'h00ffffff);
    wr(32'h5aa5c33c);
    chk(rd_data, 32'h00a5c33c);
    $display("test register done");
    // Full duplex pause pairs at random levels
    fd = 1'b1;
    for (i = 0; i < 6; i++)
    begin
      lfsr = nxt(lfsr);
      hi = 2 + lfsr[2:0];
      lo = 1 + lfsr[5:4] % (hi - 1);
      ack_dly = lfsr[11:8];
      used = 15'h0;
      wr(cfg(hi, lo, lfsr[15:12], 1));
      used = 15'(hi * 64 - 1);
      cyc(3);
      chk(req, 1'b0);
      cnt0 = {n_pause, n_zero};
      used = 15'(hi * 64 + lfsr[7:6]);
      cyc(1);
      chk({req, zero}, 2'b10);
      wait_mac(cnt0);
      chk({n_pause, n_zero}, cnt0 + 16'h0100);
      cyc(4);
      chk(req, 1'b0);
      used = 15'(lo * 64);
      cyc(3);
      chk(req, 1'b0);
      used = 15'(lo * 64 - 1);
      cyc(1);
      chk({req, zero}, 2'b11);
      wait_mac(cnt0 + 16'h0100);
      chk({n_pause, n_zero}, cnt0 + 16'h0101);
    end
    used = 15'd100;
    wr(cfg(4, 2, 0, 1));
    used = 15'd10;
    cyc(4);
    chk(req, 1'b0);
    wr(cfg(4, 2, 0, 14));
    used = 15'd300;
    cyc(4);
    chk(req, 1'b0);
    tx_en = 1'b0;
    wr(cfg(4, 2, 0, 1));
    cyc(4);
    chk(req, 1'b0);
    cnt0 = {n_pause, n_zero};
    tx_en = 1'b1;
    wait_mac(cnt0);
    used = 15'd0;
    wait_mac(cnt0 + 16'h0100);
    chk({n_pause, n_zero}, cnt0 + 16'h0101);
    $display("test pause done");
    // Half duplex jam lengths for every code and speed
    fd = 1'b0;
    used = 15'd200;
    for (i = 0; i < 32; i++)
    begin
      s10 = i[4];
      wr(cfg(3, 1, i % 16, 1));
      jam(1'b1, 3'h0, jlen(i % 16, i / 16));
    end
    s10 = 1'b0;
    $display("test jam length done");
    // Class triggers: matching class jams, other class does not
    for (i = 0; i < 3; i++)
    begin
      wr(cfg(3, 1, 0, 2 << i));
      jam(1'b0, 3'(1 << i), 4);
      jam(1'b0, 3'(1 << ((i + 1) % 3)), 0);
    end
    wr(cfg(3, 1, 0, 15));
    jam(1'b0, 3'h7, 0);
    jam(1'b1, 3'h0, 4);
    used = 15'd100;
    jam(1'b1, 3'h0, 0);
    used = 15'd200;
    tx_en = 1'b0;
    jam(1'b1, 3'h0, 0);
    tx_en = 1'b1;
    fd = 1'b1;
    wr(cfg(3, 1, 0, 14));
    jam(1'b0, 3'h7, 0);
    chk(req, 1'b0);
    $display("test triggers done");
    print_verdict();
  end
endmodule
`default_nettype wire
